//--- edge_sync.sv
// two-stage synchroniser with edge detection for one link pin
`timescale 1ns/1ps
module edge_sync (
  input  wire logic clock, // sampling clock
  input  wire logic rst,   // synchronous reset
  input  wire logic d,     // asynchronous pin
  output logic      q,     // synchronised level
  output logic      rise,  // one-cycle pulse on rising edge
  output logic      fall   // one-cycle pulse on falling edge
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_s;

  sync_s r;
  sync_s next_r;

  // s1 only feeds s2 so metastability never reaches logic
  always_comb begin
    next_r = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (rst) begin
      next_r = '0;
    end
  end

  always_ff @(posedge clock) begin
    r <= next_r;
  end

  assign q    = r.s2;
  assign rise = r.s2 & ~r.s3;
  assign fall = ~r.s2 & r.s3;
endmodule : edge_sync

//--- spi_flash_device.sv
// flash device end: command decode, identification, status and array operations
`timescale 1ns/1ps
module spi_flash_device
  import spi_id_pkg::*;
(
  input  wire logic  CLOCK,       // device clock, 10 MHz
  input  wire logic  RST,         // synchronous reset, high
  spi_link_if.device LINK,        // serial link to host
  output logic       BUSY_FLAG,   // embedded operation running
  output logic       WRITE_LATCH  // write enable latch
);
  typedef struct packed {
    dev_state_e          st;
    logic [15:0]         bits;
    logic [7:0]          opcode;
    logic [23:0]         addr;
    logic [7:0]          shin;
    logic [7:0]          obyte;
    logic [2:0]          obit;
    logic [15:0]         oidx;
    logic [15:0]         pcnt;
    logic                wel;
    logic                busy;
    logic                perr;
    logic                eerr;
    logic                erasing;
    logic [addr_w-1:0]   ptr;
    logic [addr_w-1:0]   last;
    logic [15:0]         tmr;
    logic                so;
    logic                so_oe;
  } dev_s;

  dev_s              r;
  dev_s              next_r;
  logic [7:0]        mem [1 << addr_w];
  logic              mem_we;
  logic [addr_w-1:0] mem_a;
  logic [7:0]        mem_d;
  logic              cs_q;
  logic              cs_rise;
  logic              sck_rise;
  logic              sck_fall;
  logic              si_q;

  edge_sync u_cs  (.clock(CLOCK), .rst(RST), .d(LINK.cs_n), .q(cs_q), .rise(cs_rise), .fall());
  edge_sync u_sck (.clock(CLOCK), .rst(RST), .d(LINK.sck), .q(), .rise(sck_rise), .fall(sck_fall));
  edge_sync u_si  (.clock(CLOCK), .rst(RST), .d(LINK.si), .q(si_q), .rise(), .fall());

  // bits clocked in before output or data phase
  function automatic logic [15:0] hdr_bits(input logic [7:0] op);
    case (op)
      discoverable_param_read_cmd: hdr_bits = dummy_bits;
      legacy_ident_cmd, signature_byte_cmd, array_read_cmd,
      page_program_cmd, sector_erase_cmd: hdr_bits = addr_bits;
      default: hdr_bits = op_bits;
    endcase
  endfunction : hdr_bits

  // while busy only polling and recovery commands get through
  function automatic logic accepted(input logic [7:0] op, input logic busy, input logic err);
    if (!busy) begin
      accepted = 1'b1;
    end else if (err) begin
      accepted = op == status1_read_cmd || op == status2_read_cmd || op == status_clear_cmd ||
                 op == write_disable_cmd || op == soft_reset_cmd;
    end else begin
      accepted = op == status1_read_cmd || op == status2_read_cmd || op == soft_reset_cmd;
    end
  endfunction : accepted

  function automatic logic in_range(input logic [23:0] a);
    in_range = a[23:addr_w] == '0;
  endfunction : in_range

  // byte presented for output slot i, fetched fresh per byte
  function automatic logic [7:0] out_byte(input logic [7:0] op, input logic [23:0] a,
                                          input logic [15:0] i, input dev_s s);
    logic [23:0] p;
    p = a + {8'h00, i};
    out_byte = undefined_byte;
    case (op)
      legacy_ident_cmd: out_byte = (a[0] ^ i[0]) ? device_code : maker_code;
      full_ident_cmd: begin
        if (i < 16'(id_cfi_len)) begin
          out_byte = id_cfi_table[i[2:0]];
        end
      end
      signature_byte_cmd: out_byte = device_code;
      discoverable_param_read_cmd: begin
        if (p < 24'(sfdp_len)) begin
          out_byte = sfdp_table[p[2:0]];
        end
      end
      status1_read_cmd: begin
        out_byte = 8'h00;
        out_byte[sr_busy_bit] = s.busy;
        out_byte[sr_wel_bit]  = s.wel;
        out_byte[sr_eerr_bit] = s.eerr;
        out_byte[sr_perr_bit] = s.perr;
      end
      status2_read_cmd: out_byte = status2_reset;
      array_read_cmd: out_byte = mem[p[addr_w-1:0]];
      default: out_byte = undefined_byte;
    endcase
  endfunction : out_byte

  // link decode and embedded operation sequencing
  always_comb begin
    logic [7:0] b;
    b = {r.shin[6:0], si_q};
    next_r = r;
    mem_we = 1'b0;
    mem_a  = '0;
    mem_d  = 8'h00;
    // embedded operation progress; a raised error freezes it
    if (r.busy && !r.perr && !r.eerr) begin
      if (r.erasing) begin
        mem_we = 1'b1;
        mem_a  = r.ptr;
        mem_d  = 8'hFF;
        next_r.ptr = r.ptr + 1'b1;
        if (r.ptr == r.last) begin
          next_r.erasing = 1'b0;
          next_r.busy    = 1'b0;
          next_r.wel     = 1'b0;
        end
      end else if (r.tmr == 16'h0000) begin
        next_r.busy = 1'b0;
        next_r.wel  = 1'b0;
      end else begin
        next_r.tmr = r.tmr - 1'b1;
      end
    end
    if (cs_q) begin
      // deselected: frame ends, output released
      next_r.st    = ds_cmd;
      next_r.bits  = 16'h0000;
      next_r.so_oe = 1'b0;
      next_r.obit  = 3'd0;
      next_r.oidx  = 16'h0000;
      next_r.pcnt  = 16'h0000;
      if (cs_rise) begin
        case (r.opcode)
          write_enable_cmd: begin
            if (r.bits == op_bits) begin
              next_r.wel = 1'b1;
            end
          end
          write_disable_cmd: begin
            if (r.bits == op_bits) begin
              next_r.wel = 1'b0;
            end
          end
          status_clear_cmd: begin
            if (r.bits == op_bits && (r.perr || r.eerr)) begin
              next_r.busy = 1'b0;
              next_r.perr = 1'b0;
              next_r.eerr = 1'b0;
            end
          end
          soft_reset_cmd: begin
            if (r.bits == op_bits) begin
              next_r.busy    = 1'b0;
              next_r.perr    = 1'b0;
              next_r.eerr    = 1'b0;
              next_r.wel     = 1'b0;
              next_r.erasing = 1'b0;
              next_r.tmr     = 16'h0000;
            end
          end
          page_program_cmd: begin
            if (r.wel && r.bits >= addr_bits + op_bits && r.bits[2:0] == 3'd0) begin
              next_r.busy = 1'b1;
              next_r.tmr  = 16'(prog_cycles);
              next_r.perr = !in_range(r.addr);
            end
          end
          sector_erase_cmd: begin
            if (r.wel && r.bits == addr_bits) begin
              next_r.busy    = 1'b1;
              next_r.eerr    = !in_range(r.addr);
              next_r.erasing = in_range(r.addr);
              next_r.ptr     = {r.addr[addr_w-1:sector_w], {sector_w{1'b0}}};
              next_r.last    = {r.addr[addr_w-1:sector_w], {sector_w{1'b1}}};
            end
          end
          bulk_erase_cmd: begin
            if (r.wel && r.bits == op_bits) begin
              next_r.busy    = 1'b1;
              next_r.erasing = 1'b1;
              next_r.ptr     = '0;
              next_r.last    = '1;
            end
          end
          // mode_exit_cmd: no enhanced read mode is kept, so exit has nothing to undo
          default: next_r.opcode = r.opcode;
        endcase
        next_r.opcode = no_cmd;
      end
    end else begin
      if (sck_rise) begin
        next_r.bits = r.bits + 1'b1;
        next_r.shin = b;
        case (r.st)
          ds_cmd: begin
            if (r.bits == op_bits - 1'b1) begin
              if (!accepted(b, r.busy, r.perr || r.eerr)) begin
                next_r.opcode = no_cmd;
                next_r.st     = ds_drop;
              end else begin
                next_r.opcode = b;
                if (b == full_ident_cmd || b == status1_read_cmd || b == status2_read_cmd) begin
                  next_r.st = ds_out;
                end else if (hdr_bits(b) > op_bits) begin
                  next_r.st = ds_addr;
                end else begin
                  next_r.st = ds_drop;
                end
              end
            end
          end
          ds_addr: begin
            if (r.bits < addr_bits) begin
              next_r.addr = {r.addr[22:0], si_q};
            end
            if (r.bits + 1'b1 == hdr_bits(r.opcode)) begin
              case (r.opcode)
                page_program_cmd: next_r.st = ds_in;
                sector_erase_cmd: next_r.st = ds_drop;
                default: next_r.st = ds_out;
              endcase
            end
          end
          ds_in: begin
            if (r.bits[2:0] == 3'd7) begin
              next_r.pcnt = r.pcnt + 1'b1;
              if (r.wel && in_range(r.addr)) begin
                mem_we = 1'b1;
                mem_a  = {r.addr[addr_w-1:page_w], page_w'(r.addr[page_w-1:0] + r.pcnt[page_w-1:0])};
                mem_d  = mem[mem_a] & b;
              end
            end
          end
          default: next_r.st = r.st;
        endcase
      end
      if (sck_fall && r.st == ds_out) begin
        next_r.so_oe = 1'b1;
        next_r.obit  = r.obit + 1'b1;
        if (r.obit == 3'd0) begin
          next_r.obyte = out_byte(r.opcode, r.addr, r.oidx, r);
          next_r.so    = next_r.obyte[7];
          next_r.oidx  = r.oidx + 1'b1;
        end else begin
          next_r.so = r.obyte[7 - r.obit];
        end
      end
    end
    if (RST) begin
      next_r        = '0;
      next_r.st     = ds_cmd;
      next_r.opcode = no_cmd;
      mem_we        = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    r <= next_r;
  end

  // array port; no reset so it maps onto block memory
  always_ff @(posedge CLOCK) begin
    if (mem_we) begin
      mem[mem_a] <= mem_d;
    end
  end

  assign LINK.so     = r.so;
  assign LINK.so_oe  = r.so_oe;
  assign BUSY_FLAG   = r.busy;
  assign WRITE_LATCH = r.wel;
endmodule : spi_flash_device

//--- spi_flash_host.sv
// host controller end: frames one command with address, dummy, write and read bytes
`timescale 1ns/1ps
module spi_flash_host
  import spi_id_pkg::*;
(
  input  wire logic  CLOCK,    // host clock, 10 MHz
  input  wire logic  RST,      // synchronous reset, high
  spi_link_if.host   LINK,     // serial link to device
  input  wire logic  START,    // pulse: begin command
  input  wire logic [7:0]  OPCODE,   // command opcode
  input  wire logic [23:0] ADDR,     // 24-bit address
  input  wire logic  ADDR_EN,  // send address bytes
  input  wire logic  DUMMY_EN, // send eight dummy cycles
  input  wire logic [9:0]  WR_COUNT, // bytes to write, 0..512
  input  wire logic [7:0]  WR_DATA,  // next write byte
  input  wire logic [15:0] RD_COUNT, // bytes to read
  output logic       BUSY,     // command in progress
  output logic       WR_TAKE,  // pulse: WR_DATA consumed
  output logic [7:0] RD_DATA,  // last byte read
  output logic       RD_VALID, // pulse: RD_DATA new
  output logic       DONE      // pulse: command finished
);
  typedef struct packed {
    host_state_e st;
    logic [7:0]  div;
    logic        sck;
    logic        cs_n;
    logic        mosi;
    logic [2:0]  bitn;
    logic [15:0] idx;
    logic        pre;
    logic [7:0]  op;
    logic [23:0] addr;
    logic        aen;
    logic        den;
    logic [15:0] wcnt;
    logic [15:0] rcnt;
    logic [7:0]  txb;
    logic [7:0]  rxb;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        wr_take;
    logic        done;
    logic        busy;
    logic        sent;
  } host_s;

  host_s r;
  host_s next_r;
  logic  so_q;

  edge_sync u_so (.clock(CLOCK), .rst(RST), .d(LINK.so_wire), .q(so_q), .rise(), .fall());

  function automatic logic [15:0] hdr_len(input host_s s);
    hdr_len = 16'h0001 + (s.aen ? 16'h0003 : 16'h0000) + (s.den ? 16'h0001 : 16'h0000);
  endfunction : hdr_len

  function automatic logic [15:0] frame_len(input host_s s);
    frame_len = s.pre ? 16'h0001 : hdr_len(s) + s.wcnt + s.rcnt;
  endfunction : frame_len

  // byte sent in slot k; write slots pull WR_DATA
  function automatic logic [7:0] tx_byte(input host_s s, input logic [15:0] k, input logic [7:0] wd);
    if (k == 16'h0000) begin
      tx_byte = s.pre ? write_enable_cmd : s.op;
    end else if (s.aen && k < 16'h0004) begin
      tx_byte = s.addr[8 * (3 - k[1:0]) +: 8];
    end else if (k < hdr_len(s)) begin
      tx_byte = 8'h00;
    end else if (k < hdr_len(s) + s.wcnt) begin
      tx_byte = wd;
    end else begin
      tx_byte = 8'h00;
    end
  endfunction : tx_byte

  function automatic logic is_wr(input host_s s, input logic [15:0] k);
    is_wr = !s.pre && k >= hdr_len(s) && k < hdr_len(s) + s.wcnt;
  endfunction : is_wr

  // link framing; sck is divided down from CLOCK
  always_comb begin
    logic [15:0] k;
    k = r.idx + 1'b1;
    next_r = r;
    next_r.rd_valid = 1'b0;
    next_r.wr_take  = 1'b0;
    next_r.done     = 1'b0;
    if (r.div != 8'h00) begin
      next_r.div = r.div - 1'b1;
    end
    case (r.st)
      hs_idle: begin
        if (START) begin
          next_r.busy = 1'b1;
          next_r.op   = OPCODE;
          next_r.addr = ADDR;
          next_r.aen  = ADDR_EN;
          next_r.den  = DUMMY_EN;
          next_r.wcnt = (WR_COUNT > 10'(page_bytes)) ? 16'(page_bytes) : {6'h00, WR_COUNT};
          next_r.rcnt = RD_COUNT;
          next_r.pre  = OPCODE == page_program_cmd || OPCODE == sector_erase_cmd ||
                        OPCODE == bulk_erase_cmd;
          next_r.st   = hs_gap;
          next_r.div  = 8'h00;
          next_r.cs_n = 1'b1;
          next_r.idx  = 16'h0000;
          next_r.sent = 1'b0;
        end
      end
      hs_shift: begin
        if (r.div == 8'h00) begin
          next_r.div = 8'(sck_half_cycles - 1);
          if (!r.sck) begin
            next_r.sck = 1'b1;
            next_r.rxb = {r.rxb[6:0], so_q};
            if (r.bitn == 3'd7 && !r.pre && r.idx >= hdr_len(r) + r.wcnt) begin
              next_r.rd_data  = {r.rxb[6:0], so_q};
              next_r.rd_valid = 1'b1;
            end
          end else begin
            next_r.sck  = 1'b0;
            next_r.bitn = r.bitn + 1'b1;
            if (r.bitn == 3'd7) begin
              if (k == frame_len(r)) begin
                next_r.st = hs_tail;
              end else begin
                next_r.idx     = k;
                next_r.txb     = tx_byte(r, k, WR_DATA);
                next_r.mosi    = next_r.txb[7];
                next_r.wr_take = is_wr(r, k);
              end
            end else begin
              next_r.mosi = r.txb[6 - r.bitn];
            end
          end
        end
      end
      hs_tail: begin
        if (r.div == 8'h00) begin
          next_r.cs_n = 1'b1;
          next_r.st   = hs_gap;
          next_r.sent = 1'b1;
          next_r.div  = 8'(sck_half_cycles - 1);
        end
      end
      // sent tells a gap before a frame from a gap after one
      hs_gap: begin
        if (r.div == 8'h00) begin
          if (!r.sent) begin
            next_r.st   = hs_shift;
            next_r.cs_n = 1'b0;
            next_r.idx  = 16'h0000;
            next_r.bitn = 3'd0;
            next_r.sck  = 1'b0;
            next_r.div  = 8'(sck_half_cycles - 1);
            next_r.txb  = tx_byte(r, 16'h0000, WR_DATA);
            next_r.mosi = next_r.txb[7];
          end else if (r.pre) begin
            // write enable frame done: one more gap, then the real command
            next_r.pre  = 1'b0;
            next_r.sent = 1'b0;
            next_r.div  = 8'(sck_half_cycles - 1);
          end else begin
            next_r.st   = hs_idle;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
          end
        end
      end
      default: next_r.st = hs_idle;
    endcase
    if (RST) begin
      next_r      = '0;
      next_r.st   = hs_idle;
      next_r.cs_n = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    r <= next_r;
  end

  assign LINK.cs_n = r.cs_n;
  assign LINK.sck  = r.sck;
  assign LINK.si   = r.mosi;
  assign BUSY      = r.busy;
  assign WR_TAKE   = r.wr_take;
  assign RD_DATA   = r.rd_data;
  assign RD_VALID  = r.rd_valid;
  assign DONE      = r.done;
endmodule : spi_flash_host

//--- spi_id_pkg.sv
// shared opcodes, identity values, geometry and timing for the serial flash link
package spi_id_pkg;
  // command opcodes
  localparam logic [7:0] write_enable_cmd            = 8'h06;
  localparam logic [7:0] write_disable_cmd           = 8'h04;
  localparam logic [7:0] status_clear_cmd            = 8'h30;
  localparam logic [7:0] soft_reset_cmd              = 8'hF0;
  localparam logic [7:0] mode_exit_cmd               = 8'hFF;
  localparam logic [7:0] array_read_cmd              = 8'h03;
  localparam logic [7:0] page_program_cmd            = 8'h02;
  localparam logic [7:0] sector_erase_cmd            = 8'hD8;
  localparam logic [7:0] bulk_erase_cmd              = 8'hC7;
  localparam logic [7:0] legacy_ident_cmd            = 8'h90;
  localparam logic [7:0] full_ident_cmd              = 8'h9F;
  localparam logic [7:0] signature_byte_cmd          = 8'hAB;
  localparam logic [7:0] discoverable_param_read_cmd = 8'h5A;
  localparam logic [7:0] status1_read_cmd            = 8'h05;
  localparam logic [7:0] status2_read_cmd            = 8'h07;
  localparam logic [7:0] no_cmd                      = 8'h00;
  // identity values, arbitrary
  localparam logic [7:0] maker_code  = 8'hA5;
  localparam logic [7:0] device_code = 8'h3C;
  localparam int         id_cfi_len  = 8;
  localparam logic [7:0] id_cfi_table [id_cfi_len] = '{8'hA5, 8'h02, 8'h20, 8'h4D, 8'h00, 8'h80, 8'h51, 8'h52};
  localparam int         sfdp_len    = 8;
  localparam logic [7:0] sfdp_table [sfdp_len] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hFF};
  localparam logic [7:0] undefined_byte = 8'hFF;
  localparam logic [7:0] status2_reset  = 8'h00;
  // array geometry
  localparam int addr_w       = 12;
  localparam int page_w       = 9;
  localparam int sector_w     = 10;
  localparam int page_bytes   = 512;
  // status register 1 bit positions
  localparam int sr_busy_bit  = 0;
  localparam int sr_wel_bit   = 1;
  localparam int sr_eerr_bit  = 5;
  localparam int sr_perr_bit  = 6;
  // frame bit counts
  localparam logic [15:0] op_bits    = 16'h0008;
  localparam logic [15:0] addr_bits  = 16'h0020;
  localparam logic [15:0] dummy_bits = 16'h0028;
  // timing
  localparam int clock_period_ns = 100;
  localparam int prog_time_ns    = 5000;
  localparam int prog_cycles     = (prog_time_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int sck_half_ns     = 1000;
  localparam int sck_half_cycles = (sck_half_ns + clock_period_ns - 1) / clock_period_ns;
  // state enumerations
  typedef enum logic [2:0] {ds_cmd, ds_addr, ds_out, ds_in, ds_drop} dev_state_e;
  typedef enum logic [1:0] {hs_idle, hs_shift, hs_tail, hs_gap} host_state_e;
endpackage : spi_id_pkg

//--- spi_link_asserts.sv
// link timing assertions for the serial flash interface
`timescale 1ns/1ps
module spi_link_asserts (
  input wire logic CLOCK, // sampling clock
  input wire logic RST,   // sync reset
  input wire logic cs_n,  // chip select
  input wire logic sck,   // serial clock
  input wire logic si,    // host data
  input wire logic so,    // device data
  input wire logic so_oe  // device drives so
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // high phase of ten clocks, then low
  sequence high_phase;
    sck [*8] ##1 sck ##1 !sck;
  endsequence
  // select edge followed by a quiet setup time
  sequence quiet_setup;
    !sck [*8];
  endsequence
  sck_high_len_a: assert property ($rose(sck) |=> high_phase) else $error("sck high phase length");
  sck_idle_a: assert property (cs_n |-> !sck) else $error("sck moves while deselected");
  si_hold_a: assert property (sck && $past(sck) |-> $stable(si)) else $error("si moved in sck high");
  so_hold_a: assert property (sck && $past(sck) && so_oe |-> $stable(so)) else $error("so moved in sck high");
  so_start_a: assert property ($rose(so_oe) |-> !cs_n && !sck) else $error("so driven off a falling edge");
  so_release_a: assert property ($rose(cs_n) |-> ##[1:6] !so_oe) else $error("so not released");
  cs_gap_a: assert property ($rose(cs_n) |=> cs_n [*8]) else $error("deselect gap too short");
  cs_setup_a: assert property ($fell(cs_n) |=> quiet_setup) else $error("sck too soon after select");
endmodule : spi_link_asserts

//--- spi_link_if.sv
// serial flash link between host controller and flash device
`timescale 1ns/1ps
interface spi_link_if;
  logic cs_n;    // chip select, low active
  logic sck;     // serial clock from host
  logic si;      // host to device data
  logic so;      // device to host data
  logic so_oe;   // device drives so
  logic so_wire; // resolved line, pulled high when undriven

  assign so_wire = so_oe ? so : 1'b1;

  modport device (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input so_wire);
endinterface : spi_link_if

//--- tb_top.sv
// self-checking bench: host and device ends joined on one link
`timescale 1ns/1ps
module tb_top;
  import spi_id_pkg::*;
  logic        CLOCK = 0, RST = 1, START = 0, ADDR_EN = 0, DUMMY_EN = 0, quiet = 0;
  logic [7:0]  OPCODE = 8'h00, WR_DATA = 8'h00, RD_DATA;
  logic [23:0] ADDR = 24'h00_0000;
  logic [9:0]  WR_COUNT = 10'h000;
  logic [15:0] RD_COUNT = 16'h0000, n;
  logic        BUSY, WR_TAKE, RD_VALID, DONE, BUSY_FLAG, WRITE_LATCH;
  logic [15:0] notes[$];
  logic [7:0]  wd[4], pa[4] = '{default: 8'hFF};
  int          failures = 0, tests_run = 0, wi = 0, a;
  spi_link_if link ();
  spi_flash_device i_spi_flash_device (.CLOCK, .RST, .LINK(link), .BUSY_FLAG, .WRITE_LATCH);
  spi_flash_host i_spi_flash_host (.CLOCK, .RST, .LINK(link), .START, .OPCODE, .ADDR, .ADDR_EN, .DUMMY_EN,
    .WR_COUNT, .WR_DATA, .RD_COUNT, .BUSY, .WR_TAKE, .RD_DATA, .RD_VALID, .DONE);
  spi_link_asserts i_spi_link_asserts (.CLOCK, .RST, .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
    .so(link.so), .so_oe(link.so_oe));
  initial forever #50 CLOCK = ~CLOCK;
  // next write byte once the host has taken the current one
  always @(posedge CLOCK) if (WR_TAKE) begin
    WR_DATA <= wd[(wi + 1) % 4];
    wi <= wi + 1;
  end
  // compare each read byte outside wait_ready polls with the oldest masked note; an empty queue forces a mismatch
  always @(posedge CLOCK) if (RD_VALID === 1'b1 && !quiet) begin
    n = notes.size() ? notes.pop_front() : 16'h0001;
    tests_run++;
    if ((RD_DATA & n[15:8]) !== n[7:0]) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, RD_DATA, n[7:0]);
    end
  end
  function automatic void ex(input logic [7:0] m, input logic [7:0] v);
    notes.push_back({m, v});
  endfunction : ex
  task automatic final_report();
    if (notes.size() != 0) failures++;
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // level check of a design output
  task automatic lvl(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : lvl
  // one framed command; bounded wait for completion
  task automatic cmd(input logic [7:0] op, input int ad, input int ae, input int de, input int wc, input int rc);
    int k;
    @(posedge CLOCK);
    OPCODE <= op;
    ADDR <= 24'(ad);
    ADDR_EN <= 1'(ae);
    DUMMY_EN <= 1'(de);
    WR_COUNT <= 10'(wc);
    RD_COUNT <= 16'(rc);
    wi <= 0;
    WR_DATA <= wd[0];
    START <= 1'b1;
    @(posedge CLOCK);
    START <= 1'b0;
    k = 0;
    do begin
      @(posedge CLOCK);
      #1;
      k++;
    end while (DONE !== 1'b1 && k < 30000);
    if (k >= 30000) begin
      failures++;
      final_report();
    end
  endtask : cmd
  // poll status until idle; polls are not compared
  task automatic wait_ready();
    int j;
    quiet = 1;
    for (j = 0; j < 40; j++) begin
      cmd(status1_read_cmd, 0, 0, 0, 0, 1);
      if (RD_DATA[sr_busy_bit] === 1'b0) break;
    end
    quiet = 0;
    if (j == 40) begin
      failures++;
      final_report();
    end
  endtask : wait_ready
  initial begin
    a = $urandom(42);
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    repeat (3) @(posedge CLOCK);
    cmd(bulk_erase_cmd, 0, 0, 0, 0, 0);
    lvl(BUSY_FLAG, 1'b1);
    lvl(BUSY, 1'b0);
    ex(8'h01, 8'h01);
    ex(8'h01, 8'h01);
    cmd(status1_read_cmd, 0, 0, 0, 0, 2);
    ex(8'hFF, 8'hFF);
    cmd(full_ident_cmd, 0, 0, 0, 0, 1);
    wait_ready();
    for (int i = 0; i < 8; i++) ex(8'hFF, id_cfi_table[i]);
    cmd(full_ident_cmd, 0, 0, 0, 0, 8);
    for (int i = 0; i < 2; i++) begin
      for (int k = 0; k < 3; k++) ex(8'hFF, ((i + k) % 2) ? device_code : maker_code);
      cmd(legacy_ident_cmd, i, 1, 0, 0, 3);
    end
    repeat (3) ex(8'hFF, device_code);
    cmd(signature_byte_cmd, 0, 1, 0, 0, 3);
    a = $urandom % 6;
    for (int k = 0; k < 4; k++) ex(8'hFF, (a + k < sfdp_len) ? sfdp_table[a + k] : undefined_byte);
    cmd(discoverable_param_read_cmd, a, 1, 1, 0, 4);
    repeat (2) ex(8'hFF, status2_reset);
    cmd(status2_read_cmd, 0, 0, 0, 0, 2);
    cmd(sector_erase_cmd, 0, 1, 0, 0, 0);
    ex(8'h01, 8'h01);
    repeat (6) ex(8'h00, 8'h00);
    ex(8'h01, 8'h00);
    cmd(status1_read_cmd, 0, 0, 0, 0, 8);
    // two programs on one place: the array keeps the AND of both
    for (int p = 0; p < 2; p++) begin
      foreach (wd[i]) begin
        wd[i] = 8'($urandom);
        pa[i] = pa[i] & wd[i];
      end
      cmd(page_program_cmd, 24'h00_0010, 1, 0, 4, 0);
      lvl(wi == 4, 1'b1);
      wait_ready();
    end
    foreach (pa[i]) ex(8'hFF, pa[i]);
    cmd(array_read_cmd, 24'h00_0010, 1, 0, 0, 4);
    cmd(sector_erase_cmd, 24'h00_1000, 1, 0, 0, 0);
    ex(8'h21, 8'h21);
    cmd(status1_read_cmd, 0, 0, 0, 0, 1);
    ex(8'hFF, 8'hFF);
    cmd(full_ident_cmd, 0, 0, 0, 0, 1);
    cmd(write_disable_cmd, 0, 0, 0, 0, 0);
    lvl(WRITE_LATCH, 1'b0);
    cmd(status_clear_cmd, 0, 0, 0, 0, 0);
    wait_ready();
    lvl(BUSY_FLAG, 1'b0);
    cmd(write_enable_cmd, 0, 0, 0, 0, 0);
    lvl(WRITE_LATCH, 1'b1);
    cmd(mode_exit_cmd, 0, 0, 0, 0, 0);
    ex(8'h02, 8'h02);
    cmd(status1_read_cmd, 0, 0, 0, 0, 1);
    cmd(soft_reset_cmd, 0, 0, 0, 0, 0);
    ex(8'h63, 8'h00);
    cmd(status1_read_cmd, 0, 0, 0, 0, 1);
    lvl(WRITE_LATCH, 1'b0);
    repeat (5) @(posedge CLOCK);
    final_report();
  end
endmodule : tb_top
